/* adc_result_compare_pinctl.sv */
// converter control: result pair, compare, fifo, pin control, clocking
// assumes a classic wishbone master and an analog core giving raw 12 bits
`timescale 1ns/1ns
`include "adc_ctl_params.svh"
module adc_result_compare_pinctl
	import adc_ctl_pkg::*;
#(
	parameter int FIFO_MAX = 8,
	parameter int NPINS    = 8
)
(
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// wishbone slave
	input  wire logic             cyc_i,
	input  wire logic             stb_i,
	input  wire logic             we_i,
	input  wire logic [15:0]      adr_i,
	input  wire logic [3:0]       sel_i,
	input  wire logic [31:0]      dat_i,
	output logic      [31:0]      dat_o,
	output logic                  ack_o,
	output logic                  err_o,
	// analog core
	input  wire logic [11:0]      core_raw_i,
	output logic                  core_enable_o,
	output logic [4:0]            core_channel_o,
	output logic                  converter_clock_o,
	output logic                  async_osc_run_o,
	// clock sources (asynchronous)
	input  wire logic             alternate_clock_source_i,
	input  wire logic             internal_async_clock_i,
	input  wire logic             low_power_i,
	// completion
	output logic                  conversion_complete_flag_o,
	output logic                  complete_irq_o,
	// port pins
	input  wire logic [NPINS-1:0] port_pin_i,
	input  wire logic [NPINS-1:0] port_out_i,
	input  wire logic [NPINS-1:0] port_oe_n_i,
	input  wire logic [NPINS-1:0] port_pullup_i,
	output logic [NPINS-1:0]      pin_out_o,
	output logic [NPINS-1:0]      pin_oe_n_o,
	output logic [NPINS-1:0]      pin_pullup_o,
	output logic [NPINS-1:0]      port_read_o
);
	// registers
	logic [4:0] channel_select_field;
	logic       complete_irq_enable;
	logic       continuous;
	logic       conversion_complete_flag;
	logic       compare_function_enable;
	logic       compare_greater;
	logic [1:0] clock_divide_select;
	logic [1:0] mode;
	logic [1:0] clock_source_select;
	logic [2:0] fifo_depth_field;
	logic [1:0] compare_upper_bits;
	logic [7:0] compare_value_low;
	logic [7:0] analog_pin_control_low;
	logic [7:0] result_high;
	logic [7:0] result_low;
	logic       read_lock;

	// fifo storage
	logic [4:0] chan_q [FIFO_MAX];
	logic [9:0] res_q  [FIFO_MAX];
	logic [3:0] chan_cnt;
	logic [3:0] conv_idx;
	logic [3:0] res_cnt;
	logic [3:0] rd_idx;

	// conversion engine
	conv_state_t state;
	logic [7:0]  tick_cnt;
	logic        ck_en;
	logic [9:0]  rounded;
	logic        cmp_ok;
	logic        done;

	// bus
	logic        acc;
	logic        wr;
	logic        rd;
	logic        hit;
	logic [7:0]  rdata;
	logic [15:0] idx;

	// synchronisers
	logic [1:0] alt_s;
	logic [1:0] asy_s;
	logic [1:0] lp_s;
	logic [NPINS-1:0] pin_s1;
	logic [NPINS-1:0] pin_s2;

	logic       fifo_on;
	logic [3:0] depth;

	assign fifo_on = (fifo_depth_field != 3'h0);
	assign depth   = {1'b0, fifo_depth_field} + 4'h1;
	assign idx     = adr_i[15:0] >> 2;
	assign acc     = cyc_i && stb_i && !ack_o && !err_o;
	assign wr      = acc && we_i && sel_i[0] && hit;
	assign rd      = acc && !we_i && hit;

	always_ff @(posedge clk_i)
		if (rst_i)
		begin
			alt_s  <= 2'h0;
			asy_s  <= 2'h0;
			lp_s   <= 2'h0;
			pin_s1 <= '0;
			pin_s2 <= '0;
		end
		else
		begin
			alt_s  <= {alt_s[0], alternate_clock_source_i};
			asy_s  <= {asy_s[0], internal_async_clock_i};
			lp_s   <= {lp_s[0], low_power_i};
			pin_s1 <= port_pin_i;
			pin_s2 <= pin_s1;
		end

	adc_clk_div u_div (
		.clk_i                 (clk_i),
		.rst_i                 (rst_i),
		.clock_source_select_i (clock_source_select),
		.clock_divide_select_i (clock_divide_select),
		.alt_tick_i            (alt_s[1]),
		.async_tick_i          (asy_s[1]),
		.converter_clock_o     (ck_en)
	);
	assign converter_clock_o = ck_en;

	// async oscillator stays on in wait/stop while selected
	assign async_osc_run_o = (clock_source_select == 2'h3) &&
		(state == st_conv || lp_s[1]);

	// address decode and read mux
	always_comb
	begin
		hit   = 1'b1;
		rdata = 8'h00;
		case (idx)
			`IDX_STATUS_CONTROL_ONE:
				rdata = {conversion_complete_flag, complete_irq_enable,
					continuous, channel_select_field};
			`IDX_STATUS_CONTROL_TWO:
				rdata = {2'h0, compare_function_enable, compare_greater,
					4'h0};
			`IDX_STATUS_CONTROL_THREE:
				rdata = {1'b0, clock_divide_select, 1'b0, mode,
					clock_source_select};
			`IDX_STATUS_CONTROL_FOUR:
				rdata = {5'h00, fifo_depth_field};
			`IDX_RESULT_HIGH:
				rdata = result_high;
			`IDX_RESULT_LOW:
				rdata = result_low;
			`IDX_COMPARE_VALUE_HIGH:
				rdata = {6'h00, compare_upper_bits};
			`IDX_COMPARE_VALUE_LOW:
				rdata = compare_value_low;
			`IDX_PIN_CONTROL_LOW:
				rdata = analog_pin_control_low;
			default:
				hit = 1'b0;
		endcase
	end

	// single-wait answer: ack or err one cycle after the strobe
	always_ff @(posedge clk_i)
		if (rst_i)
		begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end
		else
		begin
			ack_o <= acc && hit;
			err_o <= acc && !hit;
			dat_o <= (acc && !we_i && hit) ? {24'h000000, rdata}
				: 32'h0000_0000;
		end

	// control registers; a write to sc2..compare aborts the conversion
	always_ff @(posedge clk_i)
		if (rst_i)
		begin
			channel_select_field    <= `RST_CHANNEL;
			complete_irq_enable     <= 1'b0;
			continuous              <= 1'b0;
			compare_function_enable <= 1'b0;
			compare_greater         <= 1'b0;
			clock_divide_select     <= 2'h0;
			mode                    <= 2'h0;
			clock_source_select     <= 2'h0;
			fifo_depth_field        <= 3'h0;
			compare_upper_bits      <= 2'h0;
			compare_value_low       <= `RST_BYTE;
			analog_pin_control_low  <= `RST_BYTE;
		end
		else if (wr)
		begin
			case (idx)
				`IDX_STATUS_CONTROL_ONE:
				begin
					complete_irq_enable  <= dat_i[`SC1_IRQEN_BIT];
					continuous           <= dat_i[`SC1_CONT_BIT];
					channel_select_field <= dat_i[4:0];
				end
				`IDX_STATUS_CONTROL_TWO:
				begin
					compare_function_enable <= dat_i[`SC2_CMPEN_BIT];
					compare_greater         <= dat_i[`SC2_CMPGT_BIT];
				end
				`IDX_STATUS_CONTROL_THREE:
				begin
					clock_divide_select <= dat_i[`SC3_DIV_HI:`SC3_DIV_LO];
					mode                <= dat_i[`SC3_MODE_HI:`SC3_MODE_LO];
					clock_source_select <= dat_i[`SC3_CLK_HI:`SC3_CLK_LO];
				end
				`IDX_STATUS_CONTROL_FOUR:
					fifo_depth_field <= dat_i[2:0];
				`IDX_COMPARE_VALUE_HIGH:
					compare_upper_bits <= dat_i[1:0];
				`IDX_COMPARE_VALUE_LOW:
					compare_value_low <= dat_i[7:0];
				`IDX_PIN_CONTROL_LOW:
					analog_pin_control_low <= dat_i[7:0];
				default:
					compare_value_low <= compare_value_low;
			endcase
		end

	// rounding from the 12-bit core sample, saturating at full scale
	always_comb
	begin
		rounded = 10'h000;
		if (mode == 2'(mode_10bit))
			rounded = (core_raw_i[11:2] == 10'h3FF) ? 10'h3FF
				: core_raw_i[11:2] + {9'h000, core_raw_i[1]};
		else
			rounded = {2'h0, (core_raw_i[11:4] == 8'hFF) ? 8'hFF
				: core_raw_i[11:4] + {7'h00, core_raw_i[3]}};
	end

	// compare against the full compare value; 8-bit uses the low byte
	always_comb
	begin
		logic [9:0] cmp_val;
		cmp_val = (mode == 2'(mode_10bit)) ? {compare_upper_bits,
			compare_value_low} : {2'h0, compare_value_low};
		cmp_ok = !compare_function_enable ||
			(compare_greater ? (rounded >= cmp_val) : (rounded < cmp_val));
	end

	assign done = (state == st_conv) && ck_en && (tick_cnt == 8'h00);

	// conversion sequencer; the core stays off while channel is all ones
	always_ff @(posedge clk_i)
		if (rst_i)
		begin
			state    <= st_off;
			tick_cnt <= 8'h00;
			chan_cnt <= 4'h0;
			conv_idx <= 4'h0;
		end
		else if (wr && idx == `IDX_STATUS_CONTROL_ONE)
		begin
			// a channel write aborts and, unless off, starts anew; with the fifo on, only once depth channels are queued
			tick_cnt <= `CONV_TICKS;
			if (dat_i[4:0] == `CHANNEL_OFF)
			begin
				state    <= st_off;
				chan_cnt <= 4'h0;
			end
			else if (fifo_on)
			begin
				chan_q[chan_cnt[2:0]] <= dat_i[4:0];
				chan_cnt <= chan_cnt + 4'h1;
				conv_idx <= 4'h0;
				state    <= (chan_cnt + 4'h1 >= depth) ? st_conv : st_idle;
			end
			else
				state <= st_conv;
		end
		else if (wr && idx != `IDX_PIN_CONTROL_LOW)
		begin
			state    <= (channel_select_field == `CHANNEL_OFF) ? st_off
				: st_idle;
			chan_cnt <= 4'h0;
		end
		else
		begin
			case (state)
				st_off:
					state <= st_off;
				st_idle:
					state <= st_idle;
				st_conv:
					if (ck_en)
					begin
						if (tick_cnt != 8'h00)
							tick_cnt <= tick_cnt - 8'h01;
						else if (fifo_on && conv_idx + 4'h1 < depth)
						begin
							conv_idx <= conv_idx + 4'h1;
							tick_cnt <= `CONV_TICKS;
						end
						else if (continuous || read_lock)
						begin
							// continuous mode or a blocked result retriggers conversion
							conv_idx <= 4'h0;
							tick_cnt <= `CONV_TICKS;
						end
						else
						begin
							state    <= st_idle;
							chan_cnt <= 4'h0;
						end
					end
				default:
					state <= st_off;
			endcase
		end

	assign core_enable_o  = (state == st_conv);
	assign core_channel_o = fifo_on ? chan_q[conv_idx[2:0]]
		: channel_select_field;

	logic high_rd;
	logic low_rd;
	logic mode_wr;
	logic fifo_pop;
	assign high_rd  = rd && idx == `IDX_RESULT_HIGH;
	assign low_rd   = rd && idx == `IDX_RESULT_LOW;
	assign mode_wr  = wr && idx == `IDX_STATUS_CONTROL_THREE &&
		dat_i[`SC3_MODE_HI:`SC3_MODE_LO] != mode;
	assign fifo_pop = fifo_on && low_rd && rd_idx < res_cnt;

	// result store, read lock and completion flag
	always_ff @(posedge clk_i)
		if (rst_i)
		begin
			result_high              <= 8'h00;
			result_low               <= 8'h00;
			read_lock                <= 1'b0;
			conversion_complete_flag <= 1'b0;
			res_cnt                  <= 4'h0;
			rd_idx                   <= 4'h0;
		end
		else
		begin
			if (high_rd && mode == 2'(mode_10bit))
				read_lock <= 1'b1;
			else if (low_rd || mode != 2'(mode_10bit))
				read_lock <= 1'b0;
			if (wr && idx == `IDX_STATUS_CONTROL_ONE)
				conversion_complete_flag <= 1'b0;
			if (low_rd && !fifo_on)
				conversion_complete_flag <= 1'b0;
			if (fifo_pop)
				rd_idx <= rd_idx + 4'h1;
			// the last pop keeps the pair rather than load an empty entry
			if (fifo_pop && rd_idx + 4'h1 < res_cnt)
			begin
				result_high <= {6'h00, res_q[rd_idx[2:0] + 3'h1][9:8]};
				result_low  <= res_q[rd_idx[2:0] + 3'h1][7:0];
			end
			if (done && cmp_ok && !read_lock)
			begin
				if (fifo_on)
				begin
					res_q[conv_idx[2:0]] <= rounded;
					if (conv_idx == 4'h0)
					begin
						result_high <= {6'h00, rounded[9:8]};
						result_low  <= rounded[7:0];
						rd_idx      <= 4'h0;
					end
					res_cnt <= conv_idx + 4'h1;
					if (conv_idx + 4'h1 >= depth)
						conversion_complete_flag <= 1'b1;
				end
				else
				begin
					result_high <= {6'h00, rounded[9:8]};
					result_low  <= rounded[7:0];
					conversion_complete_flag <= 1'b1;
				end
			end
			// mode change wins over a result landing in the same cycle
			if (mode_wr)
			begin
				result_high <= 8'h00;
				result_low  <= 8'h00;
			end
		end

	assign conversion_complete_flag_o = conversion_complete_flag;
	assign complete_irq_o = conversion_complete_flag && complete_irq_enable;

	// per-pin analog takeover
	genvar g;
	generate
		for (g = 0; g < NPINS; g++)
		begin : g_pin
			assign pin_oe_n_o[g]   = analog_pin_control_low[g] ? 1'b1
				: port_oe_n_i[g];
			assign pin_out_o[g]    = analog_pin_control_low[g] ? 1'b0
				: port_out_i[g];
			assign pin_pullup_o[g] = !analog_pin_control_low[g] &&
				port_pullup_i[g];
			assign port_read_o[g]  = !analog_pin_control_low[g] &&
				pin_s2[g];
		end
	endgenerate
endmodule // adc_result_compare_pinctl

/* adc_ctl_params.svh */
// constants for the converter control block: offsets, fields, resets, timing
// assumes a byte-wide register map behind a 32-bit classic wishbone slave
`ifndef ADC_CTL_PARAMS_SVH
`define ADC_CTL_PARAMS_SVH

// printed offsets are not all multiples of four: index, byte address = 4*index
`define IDX_STATUS_CONTROL_ONE   16'h0000
`define IDX_STATUS_CONTROL_TWO   16'h0001
`define IDX_STATUS_CONTROL_THREE 16'h0002
`define IDX_STATUS_CONTROL_FOUR  16'h0003
`define IDX_RESULT_HIGH          16'h0004
`define IDX_RESULT_LOW           16'h0005
`define IDX_COMPARE_VALUE_HIGH   16'h0006
`define IDX_COMPARE_VALUE_LOW    16'h0007
`define IDX_PIN_CONTROL_LOW      16'h309C

// status_control_one fields
`define SC1_FLAG_BIT   7
`define SC1_IRQEN_BIT  6
`define SC1_CONT_BIT   5
// status_control_two fields
`define SC2_CMPEN_BIT  5
`define SC2_CMPGT_BIT  4
// status_control_three fields
`define SC3_DIV_HI     6
`define SC3_DIV_LO     5
`define SC3_MODE_HI    3
`define SC3_MODE_LO    2
`define SC3_CLK_HI     1
`define SC3_CLK_LO     0

`define RST_CHANNEL    5'h1F
`define RST_BYTE       8'h00
`define CHANNEL_OFF    5'h1F

// converter core latency stand-in, in converter clock ticks
`define CONV_TICKS     8'h17

`endif

/* adc_ctl_pkg.sv */
// types shared by the converter control block
// assumes adc_ctl_params.svh supplies the numeric constants
package adc_ctl_pkg;
	typedef enum logic [1:0] {
		clk_bus      = 2'h0,
		clk_bus_half = 2'h1,
		clk_alt      = 2'h2,
		clk_async    = 2'h3
	} clk_src_t;

	typedef enum logic [1:0] {
		mode_8bit  = 2'h0,
		mode_10bit = 2'h2
	} res_mode_t;

	typedef enum logic [2:0] {
		st_off  = 3'b001,
		st_idle = 3'b010,
		st_conv = 3'b100
	} conv_state_t;
endpackage

/* adc_clk_div.sv */
// converter clock enable generator: source select then divide by 1..8
// assumes alternate and async sources arrive already synchronised
`timescale 1ns/1ns
module adc_clk_div
	import adc_ctl_pkg::*;
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// control
	input  wire logic [1:0] clock_source_select_i,
	input  wire logic [1:0] clock_divide_select_i,
	input  wire logic       alt_tick_i,
	input  wire logic       async_tick_i,
	// output
	output logic            converter_clock_o
);
	logic       half;
	logic       alt_d;
	logic       asy_d;
	logic       src_tick;
	logic [2:0] cnt;
	logic [2:0] lim;

	always_ff @(posedge clk_i)
		if (rst_i)
			half <= 1'b0;
		else
			half <= ~half;

	// slow sources tick once per rising edge, not once per high cycle
	always_ff @(posedge clk_i)
		if (rst_i)
		begin
			alt_d <= 1'b0;
			asy_d <= 1'b0;
		end
		else
		begin
			alt_d <= alt_tick_i;
			asy_d <= async_tick_i;
		end

	always_comb
	begin
		case (clk_src_t'(clock_source_select_i))
			clk_bus:      src_tick = 1'b1;
			clk_bus_half: src_tick = half;
			clk_alt:      src_tick = alt_tick_i && !alt_d;
			clk_async:    src_tick = async_tick_i && !asy_d;
			default:      src_tick = 1'b1;
		endcase
	end

	always_comb
	begin
		case (clock_divide_select_i)
			2'h0:    lim = 3'h0;
			2'h1:    lim = 3'h1;
			2'h2:    lim = 3'h3;
			default: lim = 3'h7;
		endcase
	end

	always_ff @(posedge clk_i)
		if (rst_i)
		begin
			cnt <= 3'h0;
			converter_clock_o <= 1'b0;
		end
		else
		begin
			converter_clock_o <= src_tick && (cnt >= lim);
			if (src_tick)
				cnt <= (cnt >= lim) ? 3'h0 : cnt + 3'h1;
		end
endmodule // adc_clk_div

/* adc_result_compare_pinctl_asserts.sv */
// assertions on the ports of the converter control block
// assumes one clock, synchronous active high reset, bound below
`timescale 1ns/1ns
module adc_result_compare_pinctl_asserts #(
	parameter int NPINS = 8
)
(
	// clock and reset
	input wire logic             clk_i,
	input wire logic             rst_i,
	// bus
	input wire logic             cyc_i,
	input wire logic             stb_i,
	input wire logic             we_i,
	input wire logic [15:0]      adr_i,
	input wire logic [31:0]      dat_o,
	input wire logic             ack_o,
	input wire logic             err_o,
	// core and completion
	input wire logic             core_enable_o,
	input wire logic [4:0]       core_channel_o,
	input wire logic             conversion_complete_flag_o,
	input wire logic             complete_irq_o,
	// pins
	input wire logic [NPINS-1:0] port_oe_n_i,
	input wire logic [NPINS-1:0] port_pullup_i,
	input wire logic [NPINS-1:0] pin_oe_n_o,
	input wire logic [NPINS-1:0] pin_pullup_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	ack_one_cycle_a: assert property (ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
	bus_answer_a: assert property (cyc_i && stb_i && !ack_o && !err_o
		|=> ack_o || err_o) else $error("request not answered");
	ack_err_excl_a: assert property (!(ack_o && err_o))
		else $error("ack and err together");
	idle_data_zero_a: assert property (!ack_o |-> dat_o == 32'h0)
		else $error("read data not cleared");
	rh_upper_zero_a: assert property (
		ack_o && $past(adr_i) == 16'h0010 && !$past(we_i)
		|-> dat_o[7:2] == 6'h00) else $error("result high upper bits");
	cvh_upper_zero_a: assert property (
		ack_o && $past(adr_i) == 16'h0018 && !$past(we_i)
		|-> dat_o[7:2] == 6'h00) else $error("compare high upper bits");
	irq_needs_flag_a: assert property (
		complete_irq_o |-> conversion_complete_flag_o)
		else $error("interrupt without flag");
	idle_after_done_a: assert property (
		$rose(conversion_complete_flag_o) |-> ##1 !core_enable_o)
		else $error("core active after completion");
	off_channel_idle_a: assert property (
		core_channel_o == 5'h1F |-> !core_enable_o)
		else $error("core enabled on off channel");
	reset_idle_a: assert property (
		$fell(rst_i) |-> !core_enable_o && !conversion_complete_flag_o)
		else $error("core not idle after reset");
	pin_hiz_a: assert property (
		(~pin_oe_n_o & port_oe_n_i) == '0) else $error("pin driven");
	pin_pullup_a: assert property (
		(pin_pullup_o & ~port_pullup_i) == '0) else $error("pullup on");

	cover property ($rose(conversion_complete_flag_o));
	cover property (err_o);
	cover property (complete_irq_o);
endmodule // adc_result_compare_pinctl_asserts

bind adc_result_compare_pinctl adc_result_compare_pinctl_asserts #(
	.NPINS(NPINS)
) u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
	.err_o(err_o), .core_enable_o(core_enable_o),
	.core_channel_o(core_channel_o),
	.conversion_complete_flag_o(conversion_complete_flag_o),
	.complete_irq_o(complete_irq_o), .port_oe_n_i(port_oe_n_i),
	.port_pullup_i(port_pullup_i), .pin_oe_n_o(pin_oe_n_o),
	.pin_pullup_o(pin_pullup_o)
);

/* adc_result_compare_pinctl_tb.sv */
// self-checking bench for the converter control block
// assumes package, header, design and checker compiled before it
`timescale 1ns/1ns
`define CHECK(nm, exp, got) \
	begin \
		n_compared++; \
		if ((got) !== (exp)) \
		begin \
			error_cnt++; \
			$display("[ERR] %s expected %0h seen %0h", nm, exp, got); \
		end \
	end
module adc_result_compare_pinctl_tb;
	import adc_ctl_pkg::*;
	localparam logic [15:0] SC1 = 16'h0000, SC2 = 16'h0004, SC3 = 16'h0008;
	localparam logic [15:0] FDEP = 16'h000C, RH = 16'h0010, RL = 16'h0014;
	localparam logic [15:0] CVH = 16'h0018, CVL = 16'h001C, PIN = 16'hC270;
	// source select and divider settings with their overall division
	localparam logic [7:0] CFGS [7] = '{8'h00, 8'h28, 8'h48, 8'h68, 8'h69,
		8'h0A, 8'h0B};
	localparam int DIVS [7] = '{1, 2, 4, 8, 16, 4, 16};
	logic              clk_i, rst_i, cyc_i, stb_i, we_i, low_power_i, last_err;
	logic [15:0]       adr_i;
	logic [31:0]       dat_i, dat_o;
	logic              ack_o, err_o, core_enable_o, converter_clock_o;
	logic              async_osc_run_o, conversion_complete_flag_o;
	logic              complete_irq_o;
	logic [11:0]       core_raw_i, raw_base;
	logic [4:0]        core_channel_o;
	logic [3:0]        src_cnt;
	logic [7:0]        port_pin_i, port_out_i, port_oe_n_i, port_pullup_i;
	logic [7:0]        pin_out_o, pin_oe_n_o, pin_pullup_o, port_read_o, rd;
	int                error_cnt, n_compared, ticks;

	adc_result_compare_pinctl u_dut (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
		.core_raw_i(core_raw_i), .core_enable_o(core_enable_o),
		.core_channel_o(core_channel_o),
		.converter_clock_o(converter_clock_o),
		.async_osc_run_o(async_osc_run_o),
		.alternate_clock_source_i(src_cnt[1]),
		.internal_async_clock_i(src_cnt[3]), .low_power_i(low_power_i),
		.conversion_complete_flag_o(conversion_complete_flag_o),
		.complete_irq_o(complete_irq_o), .port_pin_i(port_pin_i),
		.port_out_i(port_out_i), .port_oe_n_i(port_oe_n_i),
		.port_pullup_i(port_pullup_i), .pin_out_o(pin_out_o),
		.pin_oe_n_o(pin_oe_n_o), .pin_pullup_o(pin_pullup_o),
		.port_read_o(port_read_o)
	);

	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	// raw sample depends on channel so queued results can be told apart
	always @(posedge clk_i)
	begin
		src_cnt <= src_cnt + 4'h1;
		core_raw_i <= raw_base + {1'b0, core_channel_o, 6'h00};
	end

	task automatic wb(input logic w, input logic [15:0] a,
		input logic [7:0] d, output logic [7:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h0, d};
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
		q = dat_o[7:0];
		last_err = err_o;
		`CHECK("bus_answer", 1'b1, n < 20)
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		logic [7:0] q;
		wb(1'b1, a, d, q);
	endtask

	task automatic rchk(input logic [15:0] a, input logic [7:0] e,
		input string nm);
		logic [7:0] q;
		wb(1'b0, a, 8'h00, q);
		`CHECK(nm, e, q)
	endtask

	task automatic wait_cc(input int lim);
		int n;
		n = 0;
		while (conversion_complete_flag_o !== 1'b1 && n < lim)
		begin
			@(posedge clk_i);
			n++;
		end
	endtask

	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge clk_i);
		error_cnt++;
		end_sim();
	end

	initial
	begin
		{rst_i, cyc_i, stb_i, we_i, low_power_i} = 5'h10;
		{adr_i, dat_i, raw_base, src_cnt} = '0;
		{port_pin_i, port_out_i, port_pullup_i} = '0;
		port_oe_n_i = 8'hFF;
		error_cnt = 0;
		n_compared = 0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rchk(PIN, 8'h00, "pin_ctl_reset");
		`CHECK("channel_off", 5'h1F, core_channel_o)
		wb(1'b0, 16'h0020, 8'h00, rd);
		`CHECK("unmapped_err", 1'b1, last_err)
		$display("test reset done");

		port_oe_n_i <= 8'h00;
		port_pullup_i <= 8'hFF;
		port_pin_i <= 8'hFF;
		port_out_i <= 8'h3C;
		wr(PIN, 8'hA5);
		rchk(PIN, 8'hA5, "pin_ctl");
		repeat (4) @(posedge clk_i);
		`CHECK("pin_oe_n", 8'hA5, pin_oe_n_o)
		`CHECK("pin_pullup", 8'h5A, pin_pullup_o)
		`CHECK("port_read", 8'h5A, port_read_o)
		`CHECK("pin_out", 8'h18, pin_out_o & 8'h5A)
		wr(PIN, 8'h00);
		repeat (4) @(posedge clk_i);
		`CHECK("pin_release", 8'h00, pin_oe_n_o)
		$display("test pins done");

		// first pass keeps the reset clock selection
		for (int i = 0; i < 7; i++)
		begin
			if (i > 0)
				wr(SC3, CFGS[i]);
			wr(SC1, 8'h00);
			repeat (4) @(posedge clk_i);
			ticks = 0;
			repeat (16 * DIVS[i])
			begin
				@(posedge clk_i);
				if (converter_clock_o === 1'b1)
					ticks++;
			end
			`CHECK("tick_count", 1'b1, ticks >= 15 && ticks <= 17)
		end
		low_power_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		`CHECK("osc_low_power", 1'b1, async_osc_run_o)
		wr(SC3, 8'h08);
		wr(SC1, 8'h1F);
		repeat (40) @(posedge clk_i);
		`CHECK("osc_bus_clock", 1'b0, async_osc_run_o)
		`CHECK("off_enable", 1'b0, core_enable_o)
		low_power_i <= 1'b0;
		$display("test clocks done");

		raw_base <= 12'hABE;
		wr(SC1, 8'h40);
		wait_cc(400);
		`CHECK("flag_set", 1'b1, conversion_complete_flag_o)
		`CHECK("irq_set", 1'b1, complete_irq_o)
		repeat (10) @(posedge clk_i);
		`CHECK("idle_enable", 1'b0, core_enable_o)
		rchk(RH, 8'h02, "rh_10bit");
		rchk(RL, 8'hB0, "rl_10bit");
		rchk(RH, 8'h02, "rh_lock");
		raw_base <= 12'h123;
		wr(SC1, 8'h00);
		repeat (100) @(posedge clk_i);
		`CHECK("flag_locked", 1'b0, conversion_complete_flag_o)
		rchk(RL, 8'hB0, "rl_locked");
		$display("test ten bit done");

		wr(SC3, 8'h00);
		rchk(RL, 8'h00, "rl_mode_change");
		rchk(RH, 8'h00, "rh_mode_change");
		raw_base <= 12'h7F9;
		wr(SC1, 8'h00);
		wait_cc(400);
		`CHECK("flag_8bit", 1'b1, conversion_complete_flag_o)
		rchk(RL, 8'h80, "rl_8bit");
		rchk(RH, 8'h00, "rh_8bit");
		$display("test eight bit done");

		wr(SC3, 8'h08);
		wr(CVH, 8'hFF);
		rchk(CVH, 8'h03, "cvh_mask");
		wr(CVH, 8'h01);
		wr(CVL, 8'hF0);
		rchk(CVL, 8'hF0, "cvl");
		wr(SC2, 8'h30);
		raw_base <= 12'h7BC;
		wr(SC1, 8'h00);
		repeat (100) @(posedge clk_i);
		`CHECK("cmp_false_flag", 1'b0, conversion_complete_flag_o)
		rchk(RL, 8'h00, "cmp_false_rl");
		raw_base <= 12'h7C0;
		wr(SC1, 8'h00);
		wait_cc(400);
		`CHECK("cmp_true_flag", 1'b1, conversion_complete_flag_o)
		rchk(RH, 8'h01, "cmp_true_rh");
		rchk(RL, 8'hF0, "cmp_true_rl");
		// less-than direction: 0x1EC below the 0x1F0 compare value
		wr(SC2, 8'h20);
		raw_base <= 12'h7B0;
		wr(SC1, 8'h00);
		wait_cc(400);
		`CHECK("cmp_less_flag", 1'b1, conversion_complete_flag_o)
		rchk(RL, 8'hEC, "cmp_less_rl");
		wr(SC2, 8'h00);
		$display("test compare done");

		wr(FDEP, 8'h01);
		raw_base <= 12'h000;
		wr(SC1, 8'h01);
		repeat (60) @(posedge clk_i);
		`CHECK("fifo_partial", 1'b0, conversion_complete_flag_o)
		wr(SC1, 8'h02);
		wait_cc(800);
		`CHECK("fifo_flag", 1'b1, conversion_complete_flag_o)
		rchk(RH, 8'h00, "fifo_rh0");
		rchk(RL, 8'h10, "fifo_rl0");
		rchk(RH, 8'h00, "fifo_rh1");
		rchk(RL, 8'h20, "fifo_rl1");
		wr(FDEP, 8'h00);
		$display("test fifo done");
		end_sim();
	end
endmodule // adc_result_compare_pinctl_tb
